// ### testbench/adc_gain_chop_config_regs_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module adc_gain_chop_config_regs_test;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic mod_clk_en = 1'b0;
	logic chop_swap = 1'b0;
	logic [5:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, reg_rvalid, chop_enable, chop_settling, measure_ok;
	logic aux_analog_pin_out, aux_analog_pin_oe;
	logic [7:0] ch0_amp_gain, ch1_amp_gain;
	logic [9:0] ch0_phase_delay;
	logic [1:0] ch0_input_sel;
	int n_mismatch = 0;
	int compares = 0;
	int i;
	always #2.5 mclk = ~mclk;
	host_model h(.*);
	adc_gain_chop_config_regs DUT(.*);
	task automatic tally_and_finish;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic rchk(input logic [5:0] a, input logic [15:0] e);
		h.rd(a);
		`CHK("rvalid", 1'b1, reg_rvalid)
		`CHK("rdata", e, reg_rdata)
	endtask
	task automatic aux(input logic [15:0] d, input logic oe, input logic o);
		h.wr(6'h06, d);
		`CHK("aux_oe", oe, aux_analog_pin_oe)
		`CHK("aux_out", o, aux_analog_pin_out)
	endtask
	task automatic wait_settle(input logic lvl);
		for (int k = 0; k < 20 && chop_settling !== lvl; k++)
			@(posedge mclk) #1;
		if (chop_settling !== lvl) begin
			n_mismatch++;
			tally_and_finish;
		end
	endtask
	// ---
	// settle length: one strobe per period, exactly 2 << code of them
	// ---
	task automatic chop(input logic [3:0] c);
		h.wr(6'h06, {3'b000, c, 1'b1, 8'h00});
		`CHK("chop_en", 1'b1, chop_enable)
		wait_settle(1'b1);
		`CHK("measure_ok", 1'b0, measure_ok)
		mod_clk_en = 1'b1;
		repeat ((2 << c) - 1) @(posedge mclk);
		@(posedge mclk) #1 mod_clk_en = 1'b0;
		`CHK("settling", 1'b1, chop_settling)
		@(posedge mclk) #1 `CHK("settled", 1'b0, chop_settling)
		`CHK("measure_ok", 1'b1, measure_ok)
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		#1 rst_n = 1'b1;
		rchk(6'h04, 16'h0000);
		rchk(6'h06, 16'h0600);
		rchk(6'h09, 16'h0000);
		rchk(6'h05, 16'h0000);
		for (i = 0; i < 8; i++) begin
			h.wr(6'h04, {9'h000, i[2:0], 1'b0, ~i[2:0]});
			`CHK("g1", 8'h01 << i, ch1_amp_gain)
			`CHK("g0", 8'h80 >> i, ch0_amp_gain)
			rchk(6'h04, {9'h000, i[2:0], 1'b0, ~i[2:0]});
		end
		aux(16'h4000, 1'b1, 1'b0);
		aux(16'h6000, 1'b1, 1'b1);
		aux(16'h2000, 1'b0, 1'b0);
		h.wr(6'h09, 16'hFFFF);
		rchk(6'h09, 16'hFFC3);
		`CHK("phase", 10'h3FF, ch0_phase_delay)
		for (i = 0; i < 4; i++) begin
			h.wr(6'h09, {10'h200, 4'h0, i[1:0]});
			`CHK("insel", i[1:0], ch0_input_sel)
			`CHK("phase", 10'h200, ch0_phase_delay)
		end
		chop(4'h0);
		@(posedge mclk) #1 chop_swap = 1'b1;
		@(posedge mclk) #1 chop_swap = 1'b0;
		wait_settle(1'b1);
		h.wr(6'h06, 16'h0600);
		wait_settle(1'b0);
		chop(4'hE);
		tally_and_finish;
	end
endmodule
bind adc_gain_chop_config_regs cfg_checker u_chk(.*);

// ### testbench/cfg_checker_assertions.sv
`timescale 1ns/10ps
module cfg_checker(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [5:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_rvalid,
	input wire logic [15:0] reg_rdata,
	input wire logic [7:0] ch0_amp_gain,
	input wire logic [7:0] ch1_amp_gain,
	input wire logic aux_analog_pin_out,
	input wire logic aux_analog_pin_oe,
	input wire logic chop_enable,
	input wire logic chop_settling,
	input wire logic measure_ok,
	input wire logic [9:0] ch0_phase_delay,
	input wire logic [1:0] ch0_input_sel
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire wg = reg_wr && reg_addr == 6'h04;
	wire wc = reg_wr && reg_addr == 6'h06;
	wire wp = reg_wr && reg_addr == 6'h09;
	a_rd_valid: assert property (
		reg_rd |=> reg_rvalid) else $error("read not answered");
	a_no_valid: assert property (
		!reg_rd |=> !reg_rvalid) else $error("stray read valid");
	a_ch1_gain: assert property (
		wg |=> ch1_amp_gain == (8'h01 << $past(reg_wdata[6:4])))
		else $error("ch1 gain wrong");
	a_ch0_gain: assert property (
		wg |=> ch0_amp_gain == (8'h01 << $past(reg_wdata[2:0])))
		else $error("ch0 gain wrong");
	a_aux_oe: assert property (
		wc |=> aux_analog_pin_oe == $past(reg_wdata[14]))
		else $error("aux enable wrong");
	a_aux_level: assert property (
		wc |=> aux_analog_pin_out == $past(reg_wdata[14] & reg_wdata[13]))
		else $error("aux level wrong");
	a_chop_en: assert property (
		wc |=> chop_enable == $past(reg_wdata[8])) else $error("chop bit");
	a_settle_excl: assert property (
		chop_settling |-> !measure_ok) else $error("measure in settle");
	a_settle_start: assert property (
		$rose(chop_enable) |-> ##2 chop_settling)
		else $error("settle not started");
	a_ch0_reserved: assert property (
		reg_rvalid && $past(reg_addr) == 6'h09
		|-> reg_rdata[5:2] == 4'h0) else $error("reserved bits set");
	a_phase_field: assert property (
		wp |=> ch0_phase_delay == $past(reg_wdata[15:6]))
		else $error("phase wrong");
	a_insel_field: assert property (
		wp |=> ch0_input_sel == $past(reg_wdata[1:0])) else $error("insel");
	c_settle: cover property (wc ##3 chop_settling);
	c_measure: cover property (chop_settling ##1 !chop_settling);
	c_read: cover property (reg_rd ##1 reg_rvalid);
endmodule

// ### testbench/host_model.sv
`timescale 1ns/10ps
module host_model(
	input wire logic mclk,
	output logic [5:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	initial begin
		reg_addr = 6'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// ---
	// word port tasks
	// ---
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		logic [15:0] m;
		m = (a == 6'h04) ? 16'h0077 : (a == 6'h06) ? 16'h7F00 : 16'hFFFF;
		@(posedge mclk) #1;
		reg_addr = a;
		reg_wdata = d & m;
		reg_wr = 1'b1;
		@(posedge mclk) #1;
		reg_wr = 1'b0;
		// stale data is scrambled so nothing leans on it
		reg_wdata = ~reg_wdata;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge mclk) #1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk) #1;
		reg_rd = 1'b0;
	endtask
endmodule

// ### verilog/adc_cfg_pkg.sv
// How it works
// - gain register at 04h, resets 0000h
// - bits 6:4 channel 1 gain, 2^code
// - bits 2:0 channel 0 gain, 2^code
// - config register at 06h, resets 0600h
// - bit 14 turns aux pin into output
// - aux pin driven to bit 13 level
// - bit 8 chop; settle 2^(code+1) periods
// - channel0 config 09h, reserved 5:2 read zero
// - phase field signed modulator-cycle delay
// - selector: normal, shorted, DC, AC test
package adc_cfg_pkg;
	localparam logic [5:0] ADDR_GAIN = 6'h04;
	localparam logic [5:0] ADDR_CFG = 6'h06;
	localparam logic [5:0] ADDR_CHANNEL0_CONFIG = 6'h09;
	localparam logic [15:0] RST_GAIN = 16'h0000;
	localparam logic [15:0] RST_CFG = 16'h0600;
	localparam logic [15:0] RST_CHANNEL0_CONFIG = 16'h0000;
	localparam int CH1_GAIN_LSB = 4;
	localparam int CH0_GAIN_LSB = 0;
	localparam int AUX_OUT_ENABLE_BIT = 14;
	localparam int AUX_OUT_LEVEL_BIT = 13;
	localparam int CHOP_DELAY_LSB = 9;
	localparam int CHOP_ENABLE_BIT = 8;
	localparam int PHASE_LSB = 6;
	localparam int INSEL_LSB = 0;
	localparam logic [15:0] CHANNEL0_CONFIG_WMASK = 16'hFFC3;
	localparam int DLY_W = 17;

	typedef enum logic [1:0] {
		INSEL_NORMAL = 2'h0,
		INSEL_SHORTED = 2'h1,
		INSEL_DC_TEST = 2'h2,
		INSEL_AC_TEST = 2'h3
	} insel_t;

	typedef enum logic [1:0] {
		CHOP_IDLE = 2'h0,
		CHOP_SETTLE = 2'h1,
		CHOP_MEASURE = 2'h3
	} chop_state_t;

	// power-of-two gain factor, 1 .. 128
	function automatic logic [7:0] gain_factor(input logic [2:0] code);
		gain_factor = 8'h01 << code;
	endfunction

	// settle length in modulator periods, 2 .. 65536
	function automatic logic [DLY_W-1:0] chop_periods(input logic [3:0] code);
		chop_periods = 17'h00002 << code;
	endfunction
endpackage

// ### verilog/adc_gain_chop_config_regs.sv
`timescale 1ns/10ps
module adc_gain_chop_config_regs
	import adc_cfg_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [5:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic mod_clk_en,
	input wire logic chop_swap,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	output logic [7:0] ch0_amp_gain,
	output logic [7:0] ch1_amp_gain,
	output logic aux_analog_pin_out,
	output logic aux_analog_pin_oe,
	output logic chop_enable,
	output logic chop_settling,
	output logic measure_ok,
	output logic [9:0] ch0_phase_delay,
	output logic [1:0] ch0_input_sel
);
	// reserved bits 5:2 of the channel 0 word are read-only zero
	function automatic logic [15:0] ch0_keep(input logic [15:0] d);
		ch0_keep = d & CHANNEL0_CONFIG_WMASK;
	endfunction

	// ---------------------------------------------------------------
	// register storage
	// ---------------------------------------------------------------
	logic [15:0] gain_r, gain_nxt;
	logic [15:0] cfg_r, cfg_nxt;
	logic [15:0] channel0_config_r, channel0_config_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;

	// reserved read-write bits are stored as written; host keeps them 0
	always_comb begin
		gain_nxt = gain_r;
		cfg_nxt = cfg_r;
		channel0_config_nxt = channel0_config_r;
		if (reg_wr) begin
			case (reg_addr)
				ADDR_GAIN: begin
					gain_nxt = reg_wdata;
				end
				ADDR_CFG: begin
					cfg_nxt = reg_wdata;
				end
				ADDR_CHANNEL0_CONFIG: begin
					channel0_config_nxt = ch0_keep(reg_wdata);
				end
				default: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	// unmapped words read as zero
	always_comb begin
		rvalid_nxt = reg_rd;
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_GAIN: begin
					rdata_nxt = gain_r;
				end
				ADDR_CFG: begin
					rdata_nxt = cfg_r;
				end
				ADDR_CHANNEL0_CONFIG: begin
					rdata_nxt = ch0_keep(channel0_config_r);
				end
				default: begin
					rdata_nxt = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gain_r <= RST_GAIN;
			cfg_r <= RST_CFG;
			channel0_config_r <= RST_CHANNEL0_CONFIG;
			rdata_r <= 16'h0000;
			rvalid_r <= 1'b0;
		end else begin
			gain_r <= gain_nxt;
			cfg_r <= cfg_nxt;
			channel0_config_r <= channel0_config_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;

	// ---------------------------------------------------------------
	// gain decode
	// ---------------------------------------------------------------
	// decoded from the next register values so outputs stay flip-flop
	// driven and track the register with no extra cycle of lag
	logic [7:0] ch0_gain_r, ch0_gain_nxt;
	logic [7:0] ch1_gain_r, ch1_gain_nxt;

	always_comb begin
		ch1_gain_nxt = gain_factor(
			gain_nxt[CH1_GAIN_LSB +: 3]);
		ch0_gain_nxt = gain_factor(
			gain_nxt[CH0_GAIN_LSB +: 3]);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ch0_gain_r <= 8'h01;
			ch1_gain_r <= 8'h01;
		end else begin
			ch0_gain_r <= ch0_gain_nxt;
			ch1_gain_r <= ch1_gain_nxt;
		end
	end

	// ---------------------------------------------------------------
	// auxiliary pin and chop controls
	// ---------------------------------------------------------------
	logic aux_out_r, aux_out_nxt;
	logic aux_oe_r, aux_oe_nxt;
	logic chop_en_r, chop_en_nxt;

	always_comb begin
		aux_oe_nxt = cfg_nxt[AUX_OUT_ENABLE_BIT];
		// pin idles low when not driven as output
		aux_out_nxt = cfg_nxt[AUX_OUT_ENABLE_BIT]
			& cfg_nxt[AUX_OUT_LEVEL_BIT];
		chop_en_nxt = cfg_nxt[CHOP_ENABLE_BIT];
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			aux_out_r <= 1'b0;
			aux_oe_r <= 1'b0;
			chop_en_r <= 1'b0;
		end else begin
			aux_out_r <= aux_out_nxt;
			aux_oe_r <= aux_oe_nxt;
			chop_en_r <= chop_en_nxt;
		end
	end

	// ---------------------------------------------------------------
	// channel 0 controls
	// ---------------------------------------------------------------
	// the phase word is passed on as raw two's complement; the sampling
	// logic downstream treats bit 9 as the sign
	logic [9:0] phase_r, phase_nxt;
	logic [1:0] insel_r, insel_nxt;

	always_comb begin
		phase_nxt = channel0_config_nxt[PHASE_LSB +: 10];
		insel_nxt = channel0_config_nxt[INSEL_LSB +: 2];
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			phase_r <= 10'h000;
			insel_r <= INSEL_NORMAL;
		end else begin
			phase_r <= phase_nxt;
			insel_r <= insel_nxt;
		end
	end

	// ---------------------------------------------------------------
	// settle status
	// ---------------------------------------------------------------
	// measure_ok idles high: outside global chop nothing holds it off
	logic settle_r, settle_nxt;
	logic ok_r, ok_nxt;
	logic settling_w, ok_w;

	always_comb begin
		settle_nxt = settling_w;
		ok_nxt = ok_w;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			settle_r <= 1'b0;
			ok_r <= 1'b1;
		end else begin
			settle_r <= settle_nxt;
			ok_r <= ok_nxt;
		end
	end

	// ---------------------------------------------------------------
	// global-chop settle timer
	// ---------------------------------------------------------------
	chop_settle_timer u_chop (
		.mclk(mclk),
		.rst_n(rst_n),
		.chop_enable(cfg_r[CHOP_ENABLE_BIT]),
		.chop_settle_delay(cfg_r[CHOP_DELAY_LSB +: 4]),
		.mod_clk_en(mod_clk_en),
		.chop_swap(chop_swap),
		.settling(settling_w),
		.measure_ok(ok_w)
	);

	assign ch0_amp_gain = ch0_gain_r;
	assign ch1_amp_gain = ch1_gain_r;
	assign aux_analog_pin_out = aux_out_r;
	assign aux_analog_pin_oe = aux_oe_r;
	assign chop_enable = chop_en_r;
	assign chop_settling = settle_r;
	assign measure_ok = ok_r;
	assign ch0_phase_delay = phase_r;
	assign ch0_input_sel = insel_r;
endmodule

// ### verilog/chop_settle_timer.sv
`timescale 1ns/10ps
module chop_settle_timer
	import adc_cfg_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic chop_enable,
	input wire logic [3:0] chop_settle_delay,
	input wire logic mod_clk_en,
	input wire logic chop_swap,
	output logic settling,
	output logic measure_ok
);
	chop_state_t state_r, state_nxt;
	logic [DLY_W-1:0] count_r, count_nxt;

	always_comb begin
		state_nxt = state_r;
		count_nxt = count_r;
		case (state_r)
			CHOP_IDLE: begin
				if (chop_enable) begin
					state_nxt = CHOP_SETTLE;
					count_nxt = chop_periods(chop_settle_delay);
				end
			end
			CHOP_SETTLE: begin
				if (!chop_enable) begin
					state_nxt = CHOP_IDLE;
				end else if (mod_clk_en) begin
					count_nxt = count_r - 17'h00001;
					if (count_r == 17'h00001) begin
						state_nxt = CHOP_MEASURE;
					end
				end
			end
			CHOP_MEASURE: begin
				if (!chop_enable) begin
					state_nxt = CHOP_IDLE;
				end else if (chop_swap) begin
					// a swap of input polarity while measuring restarts the wait; swaps during settle are ignored
					state_nxt = CHOP_SETTLE;
					count_nxt = chop_periods(chop_settle_delay);
				end
			end
			default: begin
				state_nxt = CHOP_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r <= CHOP_IDLE;
			count_r <= '0;
		end else begin
			state_r <= state_nxt;
			count_r <= count_nxt;
		end
	end

	assign settling = (state_r == CHOP_SETTLE);
	assign measure_ok = (state_r != CHOP_SETTLE);
endmodule
